/* File: core/rbc_pkg.sv */
// Constants shared by the ripple binary counter files
`default_nettype none
package rbc_pkg;
  // ****************************************
  // Counter shape
  // ****************************************
  localparam int COUNT_WIDTH = 12;
  localparam int DIVIDE_FACTOR = 4096;
  localparam int FIRST_STAGE = 0;
  localparam int LAST_STAGE = COUNT_WIDTH - 1;
  // ****************************************
  // Values
  // ****************************************
  localparam logic [COUNT_WIDTH-1:0] COUNT_ZERO = 12'h000;
  localparam logic [COUNT_WIDTH-1:0] COUNT_MAX = 12'hfff;
  localparam logic SYNC_RESET_LEVEL = 1'h0;
endpackage : rbc_pkg
`default_nettype wire

/* File: core/rbc_pin_sync.sv */
// Three-flop pin synchroniser with agreement filter
`default_nettype none
module rbc_pin_sync (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_enable,
  input wire logic pin_in,
  output logic level_out
);
  import rbc_pkg::*;

  logic sync_first;
  logic sync_second;
  logic sync_third;
  logic level;
  logic next_sync_first;
  logic next_sync_second;
  logic next_sync_third;
  logic next_level;

  // ****************************************
  // Next values
  // ****************************************
  // First flop feeds only the second; level moves once second and third agree
  always_comb begin
    next_sync_first = sync_first;
    next_sync_second = sync_second;
    next_sync_third = sync_third;
    next_level = level;
    if (clk_enable) begin
      next_sync_first = pin_in;
      next_sync_second = sync_first;
      next_sync_third = sync_second;
      if (sync_second == sync_third) begin
        next_level = sync_third;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sync_first <= SYNC_RESET_LEVEL;
      sync_second <= SYNC_RESET_LEVEL;
      sync_third <= SYNC_RESET_LEVEL;
      level <= SYNC_RESET_LEVEL;
    end else begin
      sync_first <= next_sync_first;
      sync_second <= next_sync_second;
      sync_third <= next_sync_third;
      level <= next_level;
    end
  end

  assign level_out = level;
endmodule : rbc_pin_sync
`default_nettype wire

/* File: core/rbc_counter.sv */
// Twelve-stage ripple binary counter, top level
//
// Behaviour
// - Hold a twelve-bit count and drive every stage on its own output.
// - Clear high forces count and all stage outputs to zero without a count edge.
// - Each falling edge of the count input, clear low, adds one.
// - Stages ripple: first toggles from input, each next on previous stage falling.
// - Divides by up to 4096; after all ones wraps to zero.
// - No count value is promised at power-up; clear before trusting it.
`default_nettype none
module rbc_counter (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_enable,
  input wire logic count_clk_pin,
  input wire logic clear_pin,
  output logic [rbc_pkg::COUNT_WIDTH-1:0] stage_out,
  output logic first_stage_out
);
  import rbc_pkg::*;

  logic count_level;
  logic clear_level;
  logic count_level_prev;
  logic next_count_level_prev;
  logic count_fall;
  logic [COUNT_WIDTH-1:0] stage;
  logic [COUNT_WIDTH-1:0] stage_prev;
  logic [COUNT_WIDTH-1:0] next_stage;
  logic [COUNT_WIDTH-1:0] next_stage_prev;
  logic [COUNT_WIDTH-1:0] toggle;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  rbc_pin_sync u_count_sync (
    .core_clk(core_clk),
    .reset(reset),
    .clk_enable(clk_enable),
    .pin_in(count_clk_pin),
    .level_out(count_level)
  );

  rbc_pin_sync u_clear_sync (
    .core_clk(core_clk),
    .reset(reset),
    .clk_enable(clk_enable),
    .pin_in(clear_pin),
    .level_out(clear_level)
  );

  // ****************************************
  // Count edge detect
  // ****************************************
  // falling edge only
  assign count_fall = count_level_prev & ~count_level;

  always_comb begin
    next_count_level_prev = count_level_prev;
    if (clk_enable) begin
      next_count_level_prev = count_level;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      count_level_prev <= SYNC_RESET_LEVEL;
    end else begin
      count_level_prev <= next_count_level_prev;
    end
  end

  // ****************************************
  // Ripple toggles
  // ****************************************
  // first stage toggles on count fall
  assign toggle[FIRST_STAGE] = count_fall;

  // stage toggles when previous stage fell
  genvar gi;
  generate
    for (gi = FIRST_STAGE + 1; gi <= LAST_STAGE; gi++) begin : g_ripple
      assign toggle[gi] = stage_prev[gi-1] & ~stage[gi-1];
    end
  endgenerate

  // ****************************************
  // Stage registers
  // ****************************************
  // One core cycle per stage, so a full carry takes twelve cycles, like the real chain
  always_comb begin
    next_stage = stage;
    next_stage_prev = stage_prev;
    if (clk_enable) begin
      if (clear_level) begin
        next_stage = COUNT_ZERO;
        next_stage_prev = COUNT_ZERO;
      end else begin
        // plain toggling wraps all ones to zero
        next_stage = stage ^ toggle;
        next_stage_prev = stage;
      end
    end
  end

  // reset gives zero, which is one allowed power-up value
  always_ff @(posedge core_clk) begin
    if (reset) begin
      stage <= COUNT_ZERO;
      stage_prev <= COUNT_ZERO;
    end else begin
      stage <= next_stage;
      stage_prev <= next_stage_prev;
    end
  end

  assign stage_out = stage;
  assign first_stage_out = stage[FIRST_STAGE];

  // ****************************************
  // Checks
  // ****************************************
  sequence s_quiet;
    clk_enable && !clear_level && !count_fall;
  endsequence

  sequence s_wrap_start;
    clk_enable && !clear_level && count_fall && stage == COUNT_MAX && stage_prev == COUNT_MAX;
  endsequence

  sequence s_settled;
    stage_prev == stage;
  endsequence

  property p_visible;
    @(posedge core_clk) disable iff (reset)
    first_stage_out == stage_out[FIRST_STAGE] && stage_out == stage;
  endproperty
  a_visible: assert property (p_visible) else $error("stage outputs differ from count");

  property p_clear;
    @(posedge core_clk) disable iff (reset)
    clk_enable && clear_level |=> stage_out == COUNT_ZERO ##0 stage_prev == COUNT_ZERO;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not zero the count");

  property p_advance;
    @(posedge core_clk) disable iff (reset)
    clk_enable && !clear_level && count_fall |=> first_stage_out != $past(first_stage_out);
  endproperty
  a_advance: assert property (p_advance) else $error("falling count edge did not toggle first stage");

  property p_ripple;
    @(posedge core_clk) disable iff (reset)
    clk_enable && !clear_level && stage_prev[LAST_STAGE-1] && !stage[LAST_STAGE-1]
      |=> stage[LAST_STAGE] != $past(stage[LAST_STAGE]);
  endproperty
  a_ripple: assert property (p_ripple) else $error("last stage missed fall of previous stage");

  property p_no_skip;
    @(posedge core_clk) disable iff (reset)
    clk_enable && !clear_level && !(stage_prev[LAST_STAGE-1] && !stage[LAST_STAGE-1])
      |=> stage[LAST_STAGE] == $past(stage[LAST_STAGE]);
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("last stage toggled without a carry");

  property p_wrap;
    @(posedge core_clk) disable iff (reset)
    s_wrap_start ##1 s_quiet [*8] ##1 s_quiet [*3] |=> stage_out == COUNT_ZERO;
  endproperty
  a_wrap: assert property (p_wrap) else $error("all ones did not wrap to zero in twelve cycles");

  property p_reset_value;
    @(posedge core_clk)
    reset |=> stage_out == COUNT_ZERO && !count_level_prev;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("reset left a nonzero count");

  property p_rise_ignored;
    @(posedge core_clk) disable iff (reset)
    s_quiet ##0 s_settled ##0 $rose(count_level) |=> $stable(stage_out);
  endproperty
  a_rise_ignored: assert property (p_rise_ignored) else $error("rising count edge changed the count");

  property p_clear_held;
    @(posedge core_clk) disable iff (reset)
    (clk_enable && clear_level) [*2] |-> stage_out == COUNT_ZERO;
  endproperty
  a_clear_held: assert property (p_clear_held) else $error("count left zero while clear held");

  property p_freeze;
    @(posedge core_clk) disable iff (reset)
    !clk_enable |=> $stable(stage_out) && $stable(stage_prev) && $stable(count_level_prev);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");
endmodule : rbc_counter
`default_nettype wire

/* File: testbench/rbc_pin_model.sv */
// Far-side model driving the count clock and clear pins
`default_nettype none
module rbc_pin_model (
  input wire logic core_clk,
  output logic count_clk_pin,
  output logic clear_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Pin drive
  // ****************************************
  // Parked low so no stray fall appears at release
  initial begin
    count_clk_pin = 1'h0;
    clear_pin = 1'h0;
  end
  task automatic pulse_falls(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge core_clk) count_clk_pin = 1'h1;
      repeat (3) @(negedge core_clk);
      count_clk_pin = 1'h0;
      repeat (2) @(negedge core_clk);
    end
  endtask : pulse_falls
  task automatic rise_only;
    @(negedge core_clk) count_clk_pin = 1'h1;
  endtask : rise_only
  task automatic set_clear(input logic level);
    @(negedge core_clk) clear_pin = level;
    repeat (8) @(negedge core_clk);
  endtask : set_clear
endmodule : rbc_pin_model
`default_nettype wire

/* File: testbench/ripple_binary_counter_12bit_bench.sv */
// Self-checking bench for the ripple binary counter
`default_nettype none
module ripple_binary_counter_12bit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import rbc_pkg::*;
  logic core_clk;
  logic reset;
  logic clk_enable;
  wire logic count_clk_pin;
  wire logic clear_pin;
  logic [COUNT_WIDTH-1:0] stage_out;
  logic first_stage_out;
  int num_errors;
  int checked;
  rbc_counter u_rbc_counter (
    .core_clk(core_clk),
    .reset(reset),
    .clk_enable(clk_enable),
    .count_clk_pin(count_clk_pin),
    .clear_pin(clear_pin),
    .stage_out(stage_out),
    .first_stage_out(first_stage_out)
  );
  rbc_pin_model u_rbc_pin_model (
    .core_clk(core_clk),
    .count_clk_pin(count_clk_pin),
    .clear_pin(clear_pin)
  );
  // ****************************************
  // Helpers
  // ****************************************
  always #25 core_clk = ~core_clk;
  task automatic check(input logic [COUNT_WIDTH-1:0] seen, input logic [COUNT_WIDTH-1:0] expected);
    checked++;
    if (seen !== expected) begin
      num_errors++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, expected);
    end
  endtask : check
  // Ripple needs up to eleven cycles after stage zero
  task automatic settle;
    repeat (20) @(negedge core_clk);
  endtask : settle
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_count;
    u_rbc_pin_model.set_clear(1'h1);
    u_rbc_pin_model.set_clear(1'h0);
    check(stage_out, COUNT_ZERO);
    u_rbc_pin_model.pulse_falls(5);
    settle();
    check(stage_out, 12'h005);
    check({11'h000, first_stage_out}, 12'h001);
    $display("t_count done");
  endtask : t_count
  task automatic t_rise;
    u_rbc_pin_model.rise_only();
    settle();
    check(stage_out, 12'h005);
    u_rbc_pin_model.pulse_falls(1);
    settle();
    check(stage_out, 12'h006);
    $display("t_rise done");
  endtask : t_rise
  task automatic t_clear;
    u_rbc_pin_model.set_clear(1'h1);
    check(stage_out, COUNT_ZERO);
    u_rbc_pin_model.pulse_falls(3);
    settle();
    check(stage_out, COUNT_ZERO);
    u_rbc_pin_model.set_clear(1'h0);
    u_rbc_pin_model.pulse_falls(2);
    settle();
    check(stage_out, 12'h002);
    $display("t_clear done");
  endtask : t_clear
  // Enable low freezes synchronisers too, so pin falls in that time are lost
  task automatic t_freeze;
    @(negedge core_clk) clk_enable = 1'h0;
    u_rbc_pin_model.pulse_falls(2);
    settle();
    check(stage_out, 12'h002);
    @(negedge core_clk) clk_enable = 1'h1;
    u_rbc_pin_model.pulse_falls(1);
    settle();
    check(stage_out, 12'h003);
    $display("t_freeze done");
  endtask : t_freeze
  task automatic t_reset;
    @(negedge core_clk) reset = 1'h1;
    repeat (2) @(negedge core_clk);
    reset = 1'h0;
    check(stage_out, COUNT_ZERO);
    u_rbc_pin_model.pulse_falls(1);
    settle();
    check(stage_out, 12'h001);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_wrap;
    logic seen_low_first;
    seen_low_first = 1'h0;
    u_rbc_pin_model.set_clear(1'h1);
    u_rbc_pin_model.set_clear(1'h0);
    u_rbc_pin_model.pulse_falls(DIVIDE_FACTOR - 1);
    settle();
    check(stage_out, COUNT_MAX);
    u_rbc_pin_model.pulse_falls(1);
    for (int i = 0; i < 20; i++) begin
      @(negedge core_clk);
      if (stage_out[FIRST_STAGE] === 1'h0 && stage_out[LAST_STAGE] === 1'h1) begin
        seen_low_first = 1'h1;
      end
    end
    check(stage_out, COUNT_ZERO);
    check({11'h000, first_stage_out}, 12'h000);
    check({11'h000, seen_low_first}, 12'h001);
    $display("t_wrap done");
  endtask : t_wrap
  initial begin
    core_clk = 1'h0;
    reset = 1'h1;
    clk_enable = 1'h1;
    num_errors = 0;
    checked = 0;
    repeat (6) @(negedge core_clk);
    reset = 1'h0;
    t_count();
    t_rise();
    t_clear();
    t_freeze();
    t_reset();
    t_wrap();
    print_verdict();
  end
endmodule : ripple_binary_counter_12bit_bench
`default_nettype wire
